// [logic/ces_pkg.sv]
// constants, types and register map of the cpu exception sequencer
// assumes a 32-bit classic wishbone slave port and a 32-bit stack/vector memory master
package ces_pkg;
  // wishbone register byte offsets
  localparam logic [7:0]  OFF_SYSCTRL = 8'h00;  // mode select, nmi edge
  localparam logic [7:0]  OFF_IRQEN   = 8'h04;  // enable per request line
  localparam logic [7:0]  OFF_SENSE   = 8'h08;  // two sense bits per line
  localparam logic [7:0]  OFF_STAT    = 8'h0C;  // request flags, write one to clear
  localparam logic [7:0]  OFF_PRIO    = 8'h10;  // 3-bit level per line, 4-bit spacing
  localparam logic [7:0]  OFF_MSTP    = 8'h14;  // module stop bytes a..d
  localparam logic [7:0]  OFF_FLAGS   = 8'h18;  // read-only view of flags
  // reset values
  localparam logic [2:0]  RST_SYSCTRL = 3'h0;          // interrupt control mode 0
  localparam logic [23:0] RST_PRIO    = 24'h777777;
  localparam logic [31:0] RST_MSTP    = 32'hC0FFFF3F;  // d,c,b,a from top byte down
  // field positions
  localparam int MODE_LO_BIT = 0;
  localparam int MODE_HI_BIT = 1;
  localparam int NMI_EDGE_BIT = 2;  // 1: rising, 0: falling
  localparam int CCR_I_BIT   = 7;
  localparam int CCR_UI_BIT  = 6;
  localparam int EXR_T_BIT   = 7;
  // sense codes
  localparam logic [1:0]  SENSE_LEVEL = 2'h0;
  localparam logic [1:0]  SENSE_FALL  = 2'h1;
  localparam logic [1:0]  SENSE_RISE  = 2'h2;
  localparam logic [1:0]  SENSE_BOTH  = 2'h3;
  // vector numbers
  localparam logic [6:0]  VEC_RESET = 7'h00;
  localparam logic [6:0]  VEC_TRACE = 7'h05;
  localparam logic [6:0]  VEC_NMI   = 7'h07;
  localparam logic [6:0]  VEC_TRAP0 = 7'h08;
  localparam logic [6:0]  VEC_IRQ0  = 7'h10;
  localparam logic [3:0]  NMI_LEVEL = 4'h8;
  localparam logic [2:0]  TOP_MASK  = 3'h7;
  localparam logic [31:0] FRAME_BYTES = 32'h00000008;  // two longwords stacked
  localparam logic [31:0] WORD_BYTES  = 32'h00000004;

  typedef enum logic [2:0] {ST_RESET, ST_RUN, ST_PUSH_PC, ST_PUSH_EXR, ST_VEC} ces_state_type;

  typedef struct packed {
    logic        instrDone;   // one-cycle pulse at instruction end
    logic        isRte;
    logic        isTrap;
    logic [1:0]  trapNum;
    logic        noIrqCheck;  // instruction that skips interrupt detection
    logic        flagLoad;    // pipeline writes ccr/exr (e.g. return)
    logic [7:0]  ccrIn;
    logic [7:0]  exrIn;
    logic [31:0] pcNext;
    logic [31:0] sp;
  } ces_pipe_in_type;

  typedef struct packed {
    logic        hold;
    logic        pcLoad;
    logic [31:0] pcValue;
    logic        spLoad;
    logic [31:0] spValue;
    logic [7:0]  condition_code_reg;
    logic [7:0]  extended_control_reg;
    logic        periphRstN;
  } ces_pipe_out_type;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ces_mem_req_type;
endpackage : ces_pkg

// [logic/ces_sequencer.sv]
// cpu exception sequencer: reset entry/exit, trace, interrupt and trap entry
// assumes synchronous pins, a pipeline that pulses instrDone, and a memory that acks reads/writes
// Notes on behaviour
// - reset outranks all; pin low holds reset
// - reset initialises cpu state and peripherals
// - watchdog overflow resets like the pin
// - interrupt control mode is 0 after reset
// - reset exit clears trace, sets masks
// - reset ends loading pc from vector
// - all requests blocked until first instruction
// - module stop registers reset to fixed pattern
// - trace only in control mode 2
// - trace after each instruction, ignores ccr mask
// - trace clears trace flag, sets ccr mask
// - stacked trace flag stays one
// - no trace after exception return
// - interrupts accepted inside trace handler
// - interrupt stacks pc/ccr/exr, updates masks, vectors
// - trap always honoured, same stacking sequence
// - trap picks one of four vectors
// - trap sets ccr mask, mode 2 clears trace
// - nmi level 8, others eight levels
// - nmi edge select, four sense modes
// - word accesses force address bit 0 low
//
// Register access over Wishbone and the register offsets were decided locally.
module ces_sequencer #(
  parameter int NUM_IRQ = 6
) (
  input  wire logic                      core_clk,
  input  wire logic                      rstn,
  input  wire logic                      chipClearPinN,
  input  wire logic                      wdtOverflow,
  input  wire logic                      nmiPin,
  input  wire logic [NUM_IRQ-1:0]        extReqLinesN,
  input  wire ces_pkg::ces_pipe_in_type  pipeIn,
  output ces_pkg::ces_pipe_out_type      pipeOut,
  output ces_pkg::ces_mem_req_type       memReq,
  input  wire logic                      memAck,
  input  wire logic [31:0]               memRdata,
  output logic [31:0]                    moduleStop,
  input  wire logic                      cyc_i,
  input  wire logic                      stb_i,
  input  wire logic                      we_i,
  input  wire logic [7:0]                adr_i,
  input  wire logic [31:0]               dat_i,
  input  wire logic [3:0]                sel_i,
  output logic [31:0]                    dat_o,
  output logic                           ack_o
);
  import ces_pkg::*;

  // takes new data only in written byte lanes, keeps the old value in the others
  function automatic logic [31:0] mergeSel(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        old[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return old;
  endfunction : mergeSel

  // word/longword accesses never see an odd address
  function automatic logic [31:0] evenAddr(input logic [31:0] a);
    return {a[31:1], 1'b0};
  endfunction : evenAddr

  // registers
  ces_state_type           state_r;        // sequencer state
  logic [7:0]              ccr_r;          // condition_code_reg
  logic [7:0]              exr_r;          // extended_control_reg
  logic [7:0]              savedCcr_r;     // values before entry, for stacking
  logic [7:0]              savedExr_r;
  logic [31:0]             pc_r;           // return address to stack
  logic [31:0]             sp_r;           // stack_pointer at entry
  logic [6:0]              vecNum_r;       // vector being fetched
  logic                    irqBlock_r;     // requests held off after reset
  logic                    trapPend_r;     // trap waiting behind a higher exception
  logic [1:0]              trapNum_r;
  logic [2:0]              sysCtrl_r;      // system_control_reg
  logic [NUM_IRQ-1:0]      irqEn_r;
  logic [2*NUM_IRQ-1:0]    sense_r;
  logic [NUM_IRQ-1:0]      stat_r;         // request flags
  logic                    nmiPend_r;
  logic [4*NUM_IRQ-1:0]    prio_r;         // priority_level_regs
  logic [31:0]             mstp_r;         // module_stop_ctrl_regs
  logic [NUM_IRQ-1:0]      pinPrev_r;
  logic                    nmiPrev_r;
  logic                    ack_r;
  logic [31:0]             datO_r;
  logic                    pcLoad_r;
  logic                    spLoad_r;

  // reset from either source re-initialises state, flags and software registers; wishbone answer and stacked context keep their values
  wire chipInit = !chipClearPinN || wdtOverflow;
  wire mode2 = sysCtrl_r[MODE_HI_BIT] && !sysCtrl_r[MODE_LO_BIT];  // mode 0 otherwise

  // wishbone decode
  wire wbReq   = cyc_i && stb_i && !ack_r;
  wire wbWr    = wbReq && we_i;
  wire wrCtrl  = wbWr && (adr_i == OFF_SYSCTRL);
  wire wrEn    = wbWr && (adr_i == OFF_IRQEN);
  wire wrSense = wbWr && (adr_i == OFF_SENSE);
  wire wrStat  = wbWr && (adr_i == OFF_STAT);
  wire wrPrio  = wbWr && (adr_i == OFF_PRIO);
  wire wrMstp  = wbWr && (adr_i == OFF_MSTP);
  wire [31:0] statClr = mergeSel(32'h0, dat_i, sel_i);
  // merged write words, cut back to each register's own width on purpose
  wire [31:0] ctrlMrg  = mergeSel({29'h0, sysCtrl_r}, dat_i, sel_i);
  wire [31:0] enMrg    = mergeSel(32'(irqEn_r), dat_i, sel_i);
  wire [31:0] senseMrg = mergeSel(32'(sense_r), dat_i, sel_i);
  wire [31:0] prioMrg  = mergeSel(32'(prio_r), dat_i, sel_i) & 32'h00777777;

  // read multiplexer; unmapped offsets answer zero
  logic [31:0] rdData;
  always_comb begin
    rdData = 32'h0;
    case (adr_i)
      OFF_SYSCTRL: rdData = {29'h0, sysCtrl_r};
      OFF_IRQEN:   rdData = 32'(irqEn_r);
      OFF_SENSE:   rdData = 32'(sense_r);
      OFF_STAT:    rdData = 32'(stat_r);
      OFF_PRIO:    rdData = 32'(prio_r);
      OFF_MSTP:    rdData = mstp_r;
      OFF_FLAGS:   rdData = {14'h0, nmiPend_r, irqBlock_r, exr_r, ccr_r};
      default:     rdData = 32'h0;
    endcase
  end

  // level and edge detection on active-low request pins
  logic [NUM_IRQ-1:0] reqHit;
  always_comb begin
    for (int i = 0; i < NUM_IRQ; i++) begin
      case (sense_r[2*i +: 2])
        SENSE_LEVEL: reqHit[i] = !extReqLinesN[i];
        SENSE_FALL:  reqHit[i] = pinPrev_r[i] && !extReqLinesN[i];
        SENSE_RISE:  reqHit[i] = !pinPrev_r[i] && extReqLinesN[i];
        default:     reqHit[i] = pinPrev_r[i] != extReqLinesN[i];
      endcase
    end
  end
  wire nmiHit = sysCtrl_r[NMI_EDGE_BIT] ? (!nmiPrev_r && nmiPin)
                                        : (nmiPrev_r && !nmiPin);

  // highest enabled level wins, lowest line on a tie
  logic [NUM_IRQ-1:0] pendEn;
  logic [2:0]         bestLvl;
  logic [6:0]         bestVec;
  logic               bestAny;
  logic [NUM_IRQ-1:0] bestOne;
  always_comb begin
    pendEn  = stat_r & irqEn_r;
    bestLvl = 3'h0;
    bestVec = VEC_IRQ0;
    bestAny = 1'b0;
    bestOne = '0;
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (pendEn[i] && (!bestAny || prio_r[4*i +: 3] > bestLvl)) begin
        bestLvl = prio_r[4*i +: 3];
        bestVec = VEC_IRQ0 + 7'(i);
        bestAny = 1'b1;
        bestOne = '0;
        bestOne[i] = 1'b1;
      end
    end
  end

  // maskable acceptance: ccr mask in mode 0, level compare in mode 2
  wire maskOk  = mode2 ? ({1'b0, bestLvl} > {1'b0, exr_r[2:0]}) : !ccr_r[CCR_I_BIT];
  wire irqWant = nmiPend_r || (bestAny && maskOk);
  wire atRun   = state_r == ST_RUN;
  wire done    = atRun && pipeIn.instrDone;
  // trace in mode 2 only, never after a return, regardless of ccr mask
  wire traceHit = done && mode2 && exr_r[EXR_T_BIT] && !pipeIn.isRte;
  wire irqHit  = done && !pipeIn.noIrqCheck && !irqBlock_r && irqWant && !traceHit;
  wire trapNow = done ? pipeIn.isTrap : trapPend_r;
  wire trapHit = atRun && trapNow && !traceHit && !irqHit;
  wire entry   = traceHit || irqHit || trapHit;
  wire nmiTake = irqHit && nmiPend_r;
  wire [1:0] trapSel = done && pipeIn.isTrap ? pipeIn.trapNum : trapNum_r;

  // vector for the chosen exception
  logic [6:0] entryVec;
  always_comb begin
    if (traceHit) begin
      entryVec = VEC_TRACE;
    end else if (irqHit) begin
      entryVec = nmiPend_r ? VEC_NMI : bestVec;
    end else begin
      entryVec = VEC_TRAP0 + {5'h0, trapSel};
    end
  end

  // flags after entry; user bit and level kept unless an interrupt raises the level
  logic [7:0] ccrEntry;
  logic [7:0] exrEntry;
  always_comb begin
    ccrEntry = ccr_r;
    exrEntry = exr_r;
    ccrEntry[CCR_I_BIT] = 1'b1;
    if (traceHit || irqHit || mode2) begin
      exrEntry[EXR_T_BIT] = 1'b0;
    end
    if (irqHit && mode2) begin
      exrEntry[2:0] = nmiPend_r ? TOP_MASK : bestLvl;
    end
  end

  // sequencer state; pin low keeps the cpu in reset
  ces_state_type stateNxt;
  always_comb begin
    stateNxt = state_r;
    case (state_r)
      ST_RESET:    stateNxt = ST_VEC;
      ST_RUN:      stateNxt = entry ? ST_PUSH_PC : ST_RUN;
      ST_PUSH_PC:  stateNxt = memAck ? ST_PUSH_EXR : ST_PUSH_PC;
      ST_PUSH_EXR: stateNxt = memAck ? ST_VEC : ST_PUSH_EXR;
      ST_VEC:      stateNxt = memAck ? ST_RUN : ST_VEC;
      default:     stateNxt = ST_RESET;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_RESET;
    end else if (chipInit) begin
      state_r <= ST_RESET;
    end else begin
      state_r <= stateNxt;
    end
  end

  // ccr/exr: reset values, entry update, pipeline load
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ccr_r <= 8'h80;
      exr_r <= 8'h07;
    end else if (chipInit || state_r == ST_RESET) begin
      ccr_r[CCR_I_BIT] <= 1'b1;
      exr_r[EXR_T_BIT] <= 1'b0;
      exr_r[2:0]       <= TOP_MASK;
    end else if (entry) begin
      ccr_r <= ccrEntry;
      exr_r <= exrEntry;
    end else if (atRun && pipeIn.flagLoad) begin
      ccr_r <= pipeIn.ccrIn;  // a return restores the stacked trace flag
      exr_r <= pipeIn.exrIn;
    end
  end

  // capture context at entry; the stacked exr keeps its trace bit
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      savedCcr_r <= 8'h0;
      savedExr_r <= 8'h0;
      pc_r       <= 32'h0;
      sp_r       <= 32'h0;
      vecNum_r   <= VEC_RESET;
    end else if (chipInit || state_r == ST_RESET) begin
      vecNum_r <= VEC_RESET;
    end else if (entry) begin
      savedCcr_r <= ccr_r;
      savedExr_r <= exr_r;
      pc_r       <= pipeIn.pcNext;
      sp_r       <= evenAddr(pipeIn.sp);
      vecNum_r   <= entryVec;
    end else if (state_r == ST_VEC && memAck) begin
      // return address is already stacked, so pc_r is free to hold the vector
      pc_r <= memRdata;
    end
  end

  // interrupt block after reset, trap pending, one-cycle load pulses
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irqBlock_r <= 1'b1;
      trapPend_r <= 1'b0;
      trapNum_r  <= 2'h0;
      pcLoad_r   <= 1'b0;
      spLoad_r   <= 1'b0;
    end else if (chipInit) begin
      irqBlock_r <= 1'b1;
      trapPend_r <= 1'b0;
      pcLoad_r   <= 1'b0;
      spLoad_r   <= 1'b0;
    end else begin
      irqBlock_r <= irqBlock_r && !done;
      trapPend_r <= (trapPend_r || (done && pipeIn.isTrap)) && !trapHit;
      trapNum_r  <= done && pipeIn.isTrap ? pipeIn.trapNum : trapNum_r;
      pcLoad_r   <= state_r == ST_VEC && memAck;
      spLoad_r   <= state_r == ST_PUSH_EXR && memAck;
    end
  end

  // request flags; a new request wins over a software clear or an acceptance
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stat_r    <= '0;
      nmiPend_r <= 1'b0;
      pinPrev_r <= '1;
      nmiPrev_r <= 1'b1;
    end else if (chipInit) begin
      stat_r    <= '0;
      nmiPend_r <= 1'b0;
      pinPrev_r <= extReqLinesN;
      nmiPrev_r <= nmiPin;
    end else begin
      stat_r    <= (stat_r & ~(wrStat ? statClr[NUM_IRQ-1:0] : '0)
                           & ~(irqHit && !nmiPend_r ? bestOne : '0)) | reqHit;
      nmiPend_r <= (nmiPend_r && !nmiTake) || nmiHit;
      pinPrev_r <= extReqLinesN;
      nmiPrev_r <= nmiPin;
    end
  end

  // software registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sysCtrl_r <= RST_SYSCTRL;
      irqEn_r   <= '0;
      sense_r   <= '0;
      prio_r    <= RST_PRIO[4*NUM_IRQ-1:0];
      mstp_r    <= RST_MSTP;
    end else if (chipInit) begin
      sysCtrl_r <= RST_SYSCTRL;
      irqEn_r   <= '0;
      sense_r   <= '0;
      prio_r    <= RST_PRIO[4*NUM_IRQ-1:0];
      mstp_r    <= RST_MSTP;
    end else begin
      sysCtrl_r <= wrCtrl ? ctrlMrg[2:0] : sysCtrl_r;
      irqEn_r   <= wrEn ? enMrg[NUM_IRQ-1:0] : irqEn_r;
      sense_r   <= wrSense ? senseMrg[2*NUM_IRQ-1:0] : sense_r;
      prio_r    <= wrPrio ? prioMrg[4*NUM_IRQ-1:0] : prio_r;
      mstp_r    <= wrMstp ? mergeSel(mstp_r, dat_i, sel_i) : mstp_r;
    end
  end

  // wishbone answer one cycle after the request, dropped the cycle after
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ack_r  <= 1'b0;
      datO_r <= 32'h0;
    end else begin
      ack_r  <= wbReq;
      datO_r <= wbReq ? rdData : datO_r;
    end
  end

  assign ack_o      = ack_r;
  assign dat_o      = datO_r;
  assign moduleStop = mstp_r;

  // stack and vector accesses
  always_comb begin
    memReq = '0;
    case (state_r)
      ST_PUSH_PC: begin
        memReq.valid = 1'b1;
        memReq.we    = 1'b1;
        memReq.addr  = evenAddr(sp_r - WORD_BYTES);
        memReq.wdata = {savedCcr_r, pc_r[23:0]};
      end
      ST_PUSH_EXR: begin
        memReq.valid = 1'b1;
        memReq.we    = 1'b1;
        memReq.addr  = evenAddr(sp_r - FRAME_BYTES);
        memReq.wdata = {savedExr_r, 24'h0};
      end
      ST_VEC: begin
        memReq.valid = 1'b1;
        memReq.addr  = {23'h0, vecNum_r, 2'h0};
      end
      default: memReq = '0;
    endcase
  end

  // pipeline side
  always_comb begin
    pipeOut            = '0;
    pipeOut.hold       = !atRun || entry;
    pipeOut.pcLoad     = pcLoad_r;
    pipeOut.pcValue    = pc_r;
    pipeOut.spLoad     = spLoad_r;
    pipeOut.spValue    = sp_r - FRAME_BYTES;
    pipeOut.condition_code_reg        = ccr_r;
    pipeOut.extended_control_reg        = exr_r;
    pipeOut.periphRstN = state_r != ST_RESET;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence sResetExit;
    state_r == ST_RESET && !chipInit ##1 state_r == ST_VEC;
  endsequence

  a_pin_holds_reset: assert property (!chipClearPinN |=> state_r == ST_RESET && pipeOut.hold)
    else $error("pin low did not hold reset");
  a_wdt_resets: assert property (wdtOverflow |=> state_r == ST_RESET && sysCtrl_r == RST_SYSCTRL)
    else $error("watchdog overflow did not reset");
  a_reset_flags: assert property (sResetExit |-> ccr_r[CCR_I_BIT] && !exr_r[EXR_T_BIT] && !mode2)
    else $error("flags or mode wrong after reset");
  a_reset_vector: assert property (sResetExit |-> vecNum_r == VEC_RESET && irqBlock_r)
    else $error("reset vector or block wrong");
  a_block_first_insn: assert property (irqBlock_r |-> !irqHit)
    else $error("interrupt taken before first instruction");
  a_mstp_init: assert property (chipInit |=> mstp_r == RST_MSTP)
    else $error("module stop not initialised");
  a_trace_mode0: assert property (entry && vecNum_r != VEC_TRACE ##1 vecNum_r == VEC_TRACE
                                  |-> $past(mode2))
    else $error("trace in mode 0");
  a_trace_flags: assert property (traceHit |=> !exr_r[EXR_T_BIT] && ccr_r[CCR_I_BIT]
                                  && exr_r[2:0] == $past(exr_r[2:0])
                                  && savedExr_r[EXR_T_BIT])
    else $error("trace entry flags wrong");
  a_no_trace_rte: assert property (done && pipeIn.isRte |-> !traceHit)
    else $error("trace after return");
  a_trap_vector: assert property (trapHit |=> vecNum_r == VEC_TRAP0 + {5'h0, $past(trapSel)}
                                  ##1 state_r == ST_PUSH_PC || state_r == ST_PUSH_EXR)
    else $error("trap vector wrong");
  a_even_stack: assert property (memReq.valid && memReq.we |-> !memReq.addr[0])
    else $error("odd stack address");
endmodule : ces_sequencer

// [dv/ces_mem_model.sv]
// stack and vector memory partner of the exception sequencer
// assumes one request at a time, held until acknowledged
module ces_mem_model (
  input  wire logic                     core_clk,
  input  wire logic                     rstn,
  input  wire ces_pkg::ces_mem_req_type memReq,
  input  wire logic                     slow,
  output logic                          memAck,
  output logic [31:0]                   memRdata
);
  import ces_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] waitCnt_r;  // cycles spent on the current request
  // answer after 0 or 3 wait cycles; idle data flips so stale values never match
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      memAck    <= 1'b0;
      waitCnt_r <= 2'h0;
      memRdata  <= 32'h0;
    end else if (memReq.valid && !memAck && waitCnt_r >= (slow ? 2'h3 : 2'h0)) begin
      memAck    <= 1'b1;
      memRdata  <= 32'h00010000 | memReq.addr;  // vector tag, loaded on every acknowledged read or write
      waitCnt_r <= 2'h0;
    end else begin
      memAck   <= 1'b0;
      memRdata <= ~memRdata;  // released bus
      if (memReq.valid && !memAck) begin
        waitCnt_r <= waitCnt_r + 2'h1;
      end
    end
  end
endmodule : ces_mem_model

// [dv/cpu_exception_sequencer_tb.sv]
// bench for the exception sequencer: reset, trap, trace, interrupts
// assumes ces_pkg, ces_sequencer and ces_mem_model are compiled first
module cpu_exception_sequencer_tb;
  import ces_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rstn, clrN, wdt, nmi, cyc, stb, we, ack, memAck, slow;
  logic [5:0]       irqN;     // external request lines
  logic [7:0]       adr;
  logic [3:0]       sel;
  logic [31:0]      dat, datO, memRdata, mstp, seed, rd;
  ces_pipe_in_type  pipe;
  ces_pipe_out_type po;
  ces_mem_req_type  mreq;
  logic [64:0]      expq[$];  // expected {we,addr,wdata} memory cycles
  logic [64:0]      mexp;
  int error_cnt, total_checks;

  ces_sequencer dut_u (.core_clk(core_clk), .rstn(rstn), .chipClearPinN(clrN),
    .wdtOverflow(wdt), .nmiPin(nmi), .extReqLinesN(irqN), .pipeIn(pipe), .pipeOut(po),
    .memReq(mreq), .memAck(memAck), .memRdata(memRdata), .moduleStop(mstp), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(dat), .sel_i(sel), .dat_o(datO), .ack_o(ack));
  ces_mem_model mem_u (.core_clk(core_clk), .rstn(rstn), .memReq(mreq), .slow(slow),
    .memAck(memAck), .memRdata(memRdata));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task finish_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  // one classic cycle; request held until ack is sampled, then one idle cycle
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) error_cnt++;
    rd = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask : wb

  // waits for the pc load pulse; v is the vector address the memory answered
  task pc_wait(input logic [31:0] v);
    int n;
    n = 0;
    while (po.pcLoad !== 1'b1 && n < 80) begin
      @(posedge core_clk);
      n++;
    end
    chk(n < 80, 1);
    chk(expq.size(), 0);
    chk(po.pcValue, 32'h00010000 | v);
  endtask : pc_wait

  // every acknowledged memory cycle must be the next one expected
  always @(posedge core_clk) begin
    if (rstn === 1'b1 && mreq.valid === 1'b1 && memAck === 1'b1) begin
      if (expq.size() == 0) chk(mreq.addr, 32'hFFFFFFFF);
      else begin
        mexp = expq.pop_front();
        chk({mreq.we, mreq.addr}, mexp[64:32]);
        if (mexp[64]) chk(mreq.wdata, mexp[31:0]);
      end
    end
  end

  // reset via pin (held 20 cycles) or watchdog, then vector fetch
  task do_reset(input logic viaWdt);
    expq.push_back(65'h0);
    if (viaWdt) begin
      wdt <= 1'b1;
      @(posedge core_clk);
      wdt <= 1'b0;
    end else begin
      repeat (20) @(posedge core_clk);
      chk({po.hold, po.periphRstN}, 2'b10);
      clrN <= 1'b1;
    end
    pc_wait(32'h0);
    chk({po.condition_code_reg[7], po.extended_control_reg[7]}, 2'b10);
    chk({mstp[31:30], mstp[23:0]}, {2'b11, 24'hFFFF3F});
    wb(1'b0, OFF_SYSCTRL, 32'h0);
    chk(rd[1:0], 2'h0);
  endtask : do_reset

  // load flags, end one instruction, expect entry at vec or none (vec < 0)
  task instr(input logic tr, input logic [1:0] tn, input logic exception_return_op,
             input logic [7:0] c, input logic [7:0] e, input int vec);
    logic [31:0] pc, sp;
    pc = rnd();
    sp = rnd();
    slow <= pc[0];
    pipe.flagLoad <= 1'b1;
    pipe.ccrIn    <= c;
    pipe.exrIn    <= e;
    @(posedge core_clk);
    pipe <= '{instrDone: 1'b1, isRte: exception_return_op, isTrap: tr, trapNum: tn, noIrqCheck: 1'b0,
              flagLoad: 1'b0, ccrIn: c, exrIn: e, pcNext: pc, sp: sp};
    if (vec >= 0) begin
      expq.push_back({1'b1, (sp & ~32'h1) - 32'h4, c, pc[23:0]});
      expq.push_back({1'b1, (sp & ~32'h1) - 32'h8, e, 24'h0});
      expq.push_back({1'b0, 32'(vec) << 2, 32'h0});
    end
    @(posedge core_clk);
    pipe.instrDone <= 1'b0;
    if (vec >= 0) begin
      pc_wait(32'(vec) << 2);
      chk({po.condition_code_reg[7:6], po.extended_control_reg[7]}, {1'b1, c[6], 1'b0});
      if (vec < 16 && vec != 7) chk(po.extended_control_reg[2:0], e[2:0]);
    end else repeat (6) begin
      @(posedge core_clk);
      chk(po.hold, 0);
    end
  endtask : instr

  initial begin
    seed = 32'hb9c8cfbd;
    {rstn, clrN, wdt, cyc, stb, we, slow} = 7'h0;
    {adr, sel, dat, pipe} = '0;
    nmi = 1'b1;
    irqN = 6'h3F;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    do_reset(1'b0);
    $display("test reset done");
    for (int k = 0; k < 4; k++) instr(1'b1, k[1:0], 1'b0, 8'hC0, 8'h03, 8 + k);
    $display("test trap done");
    wb(1'b1, OFF_SYSCTRL, 32'h2);
    instr(1'b0, 2'h0, 1'b0, 8'hC0, 8'h85, 5);
    instr(1'b0, 2'h0, 1'b1, 8'h00, 8'h85, -1);
    instr(1'b1, 2'h1, 1'b0, 8'h40, 8'h02, 9);
    wb(1'b1, OFF_SYSCTRL, 32'h0);
    instr(1'b0, 2'h0, 1'b0, 8'h00, 8'h80, -1);
    $display("test trace done");
    wb(1'b1, OFF_IRQEN, 32'h1);
    for (int k = 0; k < 4; k++) begin
      irqN[0] <= (k != 2);
      wb(1'b1, OFF_SENSE, 32'(k));
      wb(1'b1, OFF_STAT, 32'h3F);
      irqN[0] <= (k == 2);
      repeat (3) @(posedge core_clk);
      instr(1'b0, 2'h0, 1'b0, 8'h00, 8'h00, 16);
      irqN[0] <= 1'b1;
      @(posedge core_clk);
      wb(1'b1, OFF_STAT, 32'h3F);
    end
    nmi <= 1'b0;
    repeat (3) @(posedge core_clk);
    instr(1'b0, 2'h0, 1'b0, 8'h80, 8'h00, 7);
    $display("test interrupt done");
    wb(1'b1, OFF_SYSCTRL, 32'h2);
    wb(1'b1, OFF_MSTP, 32'h0);
    do_reset(1'b1);
    $display("test watchdog done");
    finish_test();
  end

  // hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    finish_test();
  end
endmodule : cpu_exception_sequencer_tb
